//--- verilog/dpr_pkg.sv
// Shared constants and types for the dual-port RAM port logic
`default_nettype none
package dpr_pkg;
	// Geometry
	localparam int DPR_AW = 14;
	localparam int DPR_DW = 18;
	localparam int DPR_PORTS = 2;
	// Counter value forced by a counter clear
	localparam logic [DPR_AW-1:0] DPR_CNT_CLEAR = 14'h0000;
	// Clock and port-to-port timing, in ns
	localparam int DPR_CLK_NS = 50;
	localparam int DPR_WRD_NS = 30;
	localparam int DPR_CCS_NS = 9;
	localparam int DPR_FTCD_NS = 15;
	// Write-to-read delay is a least time: round up
	localparam int DPR_WRD_CYC = (DPR_WRD_NS + DPR_CLK_NS - 1) / DPR_CLK_NS;
	// Separation limit is a longest time: round down, at least one
	localparam int DPR_CCS_CYC = (DPR_CCS_NS / DPR_CLK_NS) < 1 ? 1 : DPR_CCS_NS / DPR_CLK_NS;
	// Flow-through clock-to-data is a longest time: round up to whole cycle
	localparam int DPR_FTCD_CYC = (DPR_FTCD_NS + DPR_CLK_NS - 1) / DPR_CLK_NS;
	// Read latency in cycles after the sampling edge
	localparam int DPR_LAT_FT = 1;
	localparam int DPR_LAT_PIPE = 2;
	// Host sequencer states
	typedef enum logic [1:0] {
		DPR_HS_RUN  = 2'b01,
		DPR_HS_TURN = 2'b10
	} dpr_hst_t;
endpackage
`default_nettype wire

//--- verilog/dpr_if.sv
// Pin-level port between one host and one RAM port
`timescale 1ns/1ps
`default_nettype none
interface dpr_if
	import dpr_pkg::*;
#(
	parameter int AW = DPR_AW,
	parameter int DW = DPR_DW
) (
	input wire logic clk
);
	logic [AW-1:0] addr;
	logic          select_low_active;
	logic          select_high_active;
	logic          write_n;
	logic          oe_n;
	logic          address_strobe_n;
	logic          counter_advance_n;
	logic          counter_clear_n;
	logic          upper_byte_strobe_n;
	logic          lower_byte_strobe_n;
	logic          pipelined;
	logic [DW-1:0] host_dq;
	logic          host_oe_n;
	logic [DW-1:0] dev_dq;
	logic          dev_oe_n;
	logic [DW-1:0] dq;

	// Resolved data wire; undriven bus reads as zero
	assign dq = !dev_oe_n ? dev_dq : (!host_oe_n ? host_dq : '0);

	modport dev (
		input  addr, select_low_active, select_high_active, write_n, oe_n,
		input  address_strobe_n, counter_advance_n, counter_clear_n,
		input  upper_byte_strobe_n, lower_byte_strobe_n, pipelined, dq,
		output dev_dq, dev_oe_n
	);
	modport host (
		output addr, select_low_active, select_high_active, write_n, oe_n,
		output address_strobe_n, counter_advance_n, counter_clear_n,
		output upper_byte_strobe_n, lower_byte_strobe_n, pipelined,
		output host_dq, host_oe_n,
		input  dq
	);
endinterface
`default_nettype wire

//--- verilog/dpr_ram.sv
// Dual-port RAM end: shared array with per-port counter and output logic
//
// Summary of operation
// RL1: Inputs sampled on rising edge; OE asynchronous.
// RL2: Deselect floats outputs after the next edge.
// RL3: Strobe low loads fresh address every edge.
// RL4: Access address: external if strobe low, else counter.
// RL5: Pipelined output state follows previous cycle controls.
// RL6: Host rewrites location after turnaround no-operation.
// RL7: Counter clear costs no cycle; access proceeds.
// RL8: Cross-port write visible to read after delay.
// RL9: Beyond separation limit, data after flow-through delay.
// RL10: Cross-port timing identical in both directions.
// RL11: Host selects exactly one bank per access.
// RL12: Pipelined read data one cycle after flow-through.
// RL13: Counter priority: clear, load, advance, hold.
// RL14: Counter works regardless of chip selects.
// RL15: Select needs low-active low and high-active high.
// RL16: Writes touch only strobed byte lanes.
// RL17: One shared array, no write arbitration.
`timescale 1ns/1ps
`default_nettype none
module dpr_ram
	import dpr_pkg::*;
#(
	parameter int AW = DPR_AW,
	parameter int DW = DPR_DW
) (
	input wire logic clk,
	input wire logic rst_b,
	dpr_if.dev       lp,
	dpr_if.dev       rp
);
	localparam int BW = DW / 2;
	localparam int DEPTH = 1 << AW;

	////////////////////////////////////////////////////////////////////////////////
	// Byte-lane merge, shared by the array write and cross-port forwarding
	// Strobes are active low; an idle lane keeps the stored bits

	function automatic logic [DW-1:0] dpr_merge(
		input logic [DW-1:0] old_w,
		input logic [DW-1:0] new_w,
		input logic [1:0]    be_n
	);
		logic [DW-1:0] res;
		res = old_w;
		if (!be_n[1]) begin
			res[DW-1:BW] = new_w[DW-1:BW];
		end
		if (!be_n[0]) begin
			res[BW-1:0] = new_w[BW-1:0];
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Port pins gathered into arrays so both ports share one description

	// Storage is not reset; contents start undefined
	logic [DW-1:0] mem [0:DEPTH-1];

	logic [AW-1:0] ext_a   [DPR_PORTS];
	logic          sel_l_a [DPR_PORTS];
	logic          sel_h_a [DPR_PORTS];
	logic          wn_a    [DPR_PORTS];
	logic          oe_n_a  [DPR_PORTS];
	logic          ads_n_a [DPR_PORTS];
	logic          adv_n_a [DPR_PORTS];
	logic          clr_n_a [DPR_PORTS];
	logic [1:0]    be_n_a  [DPR_PORTS];
	logic          pipe_a  [DPR_PORTS];
	logic [DW-1:0] din_a   [DPR_PORTS];
	logic [AW-1:0] acc_a   [DPR_PORTS];
	logic          wr_a    [DPR_PORTS];
	logic [DW-1:0] dout_a  [DPR_PORTS];
	logic          doe_n_a [DPR_PORTS];

	assign ext_a[0]   = lp.addr;
	assign sel_l_a[0] = lp.select_low_active;
	assign sel_h_a[0] = lp.select_high_active;
	assign wn_a[0]    = lp.write_n;
	assign oe_n_a[0]  = lp.oe_n;
	assign ads_n_a[0] = lp.address_strobe_n;
	assign adv_n_a[0] = lp.counter_advance_n;
	assign clr_n_a[0] = lp.counter_clear_n;
	assign be_n_a[0]  = {lp.upper_byte_strobe_n, lp.lower_byte_strobe_n};
	assign pipe_a[0]  = lp.pipelined;
	assign din_a[0]   = lp.dq;

	assign ext_a[1]   = rp.addr;
	assign sel_l_a[1] = rp.select_low_active;
	assign sel_h_a[1] = rp.select_high_active;
	assign wn_a[1]    = rp.write_n;
	assign oe_n_a[1]  = rp.oe_n;
	assign ads_n_a[1] = rp.address_strobe_n;
	assign adv_n_a[1] = rp.counter_advance_n;
	assign clr_n_a[1] = rp.counter_clear_n;
	assign be_n_a[1]  = {rp.upper_byte_strobe_n, rp.lower_byte_strobe_n};
	assign pipe_a[1]  = rp.pipelined;
	assign din_a[1]   = rp.dq;

	assign lp.dev_dq   = dout_a[0];
	assign lp.dev_oe_n = doe_n_a[0];
	assign rp.dev_dq   = dout_a[1];
	assign rp.dev_oe_n = doe_n_a[1];

	////////////////////////////////////////////////////////////////////////////////
	// Per-port control, identical for both ports

	for (genvar p = 0; p < DPR_PORTS; p++) begin : g_port
		localparam int O = DPR_PORTS - 1 - p;

		logic [AW-1:0] cnt_r;
		logic [AW-1:0] cnt_nxt;
		logic          sel;
		logic          rd;
		logic [DW-1:0] ft_data;
		logic [DW-1:0] s1_data_r;
		logic          s1_drv_r;
		logic [DW-1:0] out_data_r;
		logic          out_drv_r;

		// Select is decoded afresh each edge, so a deselect costs no cycle
		// Both enables must be active at once
		assign sel = ~sel_l_a[p] & sel_h_a[p];
		assign rd  = sel & wn_a[p];
		assign wr_a[p] = sel & ~wn_a[p];

		// Chip selects deliberately absent from the counter path
		always_comb begin // RL13 RL14
			if (!clr_n_a[p]) begin
				cnt_nxt = DPR_CNT_CLEAR; // RL7
			end else if (!ads_n_a[p]) begin
				cnt_nxt = ext_a[p]; // RL3
			end else if (!adv_n_a[p]) begin
				cnt_nxt = cnt_r + 1'b1;
			end else begin
				cnt_nxt = cnt_r;
			end
		end

		// Access uses the new counter value, so a clear costs no cycle
		// Trade-off: address decode sits behind the counter mux, a longer path
		assign acc_a[p] = cnt_nxt; // RL4 RL7

		always_ff @(posedge clk or negedge rst_b) begin // RL1
			if (!rst_b) begin
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_nxt;
			end
		end

		// One clock for both ports: separation is always zero, so the
		// beyond-limit case never arises and forwarding covers every overlap
		// Same-edge write from the far port is forwarded into the read
		always_comb begin // RL8 RL9 RL10
			ft_data = mem[acc_a[p]];
			if (wr_a[O] && acc_a[O] == acc_a[p]) begin
				ft_data = dpr_merge(mem[acc_a[p]], din_a[O], be_n_a[O]);
			end
		end

		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				s1_data_r <= '0;
				s1_drv_r  <= 1'b0;
			end else begin
				s1_data_r <= ft_data;
				s1_drv_r  <= rd; // RL2
			end
		end

		// Extra register stage in pipelined mode
		// Mode is meant to be static; changing it mid-read drops a word
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				out_data_r <= '0;
				out_drv_r  <= 1'b0;
			end else if (pipe_a[p]) begin
				out_data_r <= s1_data_r; // RL12
				out_drv_r  <= s1_drv_r; // RL5
			end else begin
				out_data_r <= ft_data;
				out_drv_r  <= rd; // RL2
			end
		end

		assign dout_a[p] = out_data_r;

		// OE gates the drivers without a clock edge
		assign doe_n_a[p] = oe_n_a[p] | ~out_drv_r; // RL1
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared array; later port wins a same-address collision, no arbitration
	// Host must keep both ports off one address in one cycle

	always_ff @(posedge clk) begin // RL17
		for (int q = 0; q < DPR_PORTS; q++) begin
			if (wr_a[q]) begin
				mem[acc_a[q]] <= dpr_merge(mem[acc_a[q]], din_a[q], be_n_a[q]); // RL16
			end
		end
	end

endmodule
`default_nettype wire

//--- verilog/dpr_host.sv
// Host end: issues reads, writes and bursts on one RAM port
`timescale 1ns/1ps
`default_nettype none
module dpr_host
	import dpr_pkg::*;
#(
	parameter int   AW        = DPR_AW,
	parameter int   DW        = DPR_DW,
	parameter logic PIPELINED = 1'b0,
	parameter logic BANK_ID   = 1'b0
) (
	input  wire logic          clk,
	input  wire logic          rst_b,
	dpr_if.host                bus,
	input  wire logic          cmd_valid,
	output logic               cmd_ready,
	input  wire logic          cmd_write,
	input  wire logic          cmd_burst,
	input  wire logic          cmd_clear,
	input  wire logic [AW:0]   cmd_addr,
	input  wire logic [DW-1:0] cmd_wdata,
	input  wire logic [1:0]    cmd_be_n,
	output logic               rsp_valid,
	output logic [DW-1:0]      rsp_data
);
	localparam int LAT = PIPELINED ? DPR_LAT_PIPE : DPR_LAT_FT;
	localparam logic [1:0] TURN_LOAD = 2'(LAT - 1);

	dpr_hst_t      state_r;
	logic [1:0]    turn_cnt_r;
	logic          ready_r;
	logic [2:0]    rd_sh_r;
	logic          p_write_r, p_burst_r, p_clear_r;
	logic [AW:0]   p_addr_r;
	logic [DW-1:0] p_wdata_r;
	logic [1:0]    p_be_n_r;
	logic          take, need_turn, use_pend, use_cmd, go, hit;
	logic          s_write, s_burst, s_clear;
	logic [AW:0]   s_addr;
	logic [DW-1:0] s_wdata;
	logic [1:0]    s_be_n;
	logic          cap;

	////////////////////////////////////////////////////////////////////////////////
	// Issue selection

	assign take      = cmd_valid & ready_r;
	// Device may still drive from a recent read: wait it out
	assign need_turn = cmd_write & (|rd_sh_r[LAT-1:0]);
	assign use_pend  = (state_r == DPR_HS_TURN) && (turn_cnt_r == 2'h0);
	assign use_cmd   = (state_r == DPR_HS_RUN) && take && !need_turn;
	assign go        = use_pend | use_cmd;
	assign s_write   = use_pend ? p_write_r : cmd_write;
	assign s_burst   = use_pend ? p_burst_r : cmd_burst;
	assign s_clear   = use_pend ? p_clear_r : cmd_clear;
	assign s_addr    = use_pend ? p_addr_r : cmd_addr;
	assign s_wdata   = use_pend ? p_wdata_r : cmd_wdata;
	assign s_be_n    = use_pend ? p_be_n_r : cmd_be_n;
	// Address top bit picks the bank; other bank stays deselected
	assign hit       = go && (s_addr[AW] == BANK_ID); // RL11

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r    <= DPR_HS_RUN;
			turn_cnt_r <= 2'h0;
			ready_r    <= 1'b1;
		end else begin
			case (state_r)
				DPR_HS_RUN: begin
					if (take && need_turn) begin
						state_r    <= DPR_HS_TURN;
						turn_cnt_r <= TURN_LOAD;
						ready_r    <= 1'b0;
					end
				end
				DPR_HS_TURN: begin
					// No-operation gap ends; the held write rewrites the location
					if (turn_cnt_r == 2'h0) begin // RL6
						state_r <= DPR_HS_RUN;
						ready_r <= 1'b1;
					end else begin
						turn_cnt_r <= turn_cnt_r - 2'h1;
					end
				end
				default: begin
					state_r <= DPR_HS_RUN;
					ready_r <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			p_write_r <= 1'b0;
			p_burst_r <= 1'b0;
			p_clear_r <= 1'b0;
			p_addr_r  <= '0;
			p_wdata_r <= '0;
			p_be_n_r  <= 2'h3;
		end else if (take && need_turn && state_r == DPR_HS_RUN) begin
			p_write_r <= cmd_write;
			p_burst_r <= cmd_burst;
			p_clear_r <= cmd_clear;
			p_addr_r  <= cmd_addr;
			p_wdata_r <= cmd_wdata;
			p_be_n_r  <= cmd_be_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drive, all registered

	always_ff @(posedge clk or negedge rst_b) begin // RL1
		if (!rst_b) begin
			bus.addr                <= '0;
			bus.select_low_active   <= 1'b1;
			bus.select_high_active  <= 1'b0;
			bus.write_n             <= 1'b1;
			bus.oe_n                <= 1'b1;
			bus.address_strobe_n    <= 1'b1;
			bus.counter_advance_n   <= 1'b1;
			bus.counter_clear_n     <= 1'b1;
			bus.upper_byte_strobe_n <= 1'b1;
			bus.lower_byte_strobe_n <= 1'b1;
			bus.pipelined           <= PIPELINED;
			bus.host_dq             <= '0;
			bus.host_oe_n           <= 1'b1;
		end else begin
			bus.addr                <= s_addr[AW-1:0];
			bus.select_low_active   <= ~hit; // RL15
			bus.select_high_active  <= hit; // RL15
			bus.write_n             <= ~(hit & s_write);
			bus.oe_n                <= hit & s_write;
			// Counter commands issued even off-bank so both banks stay aligned
			bus.address_strobe_n    <= ~(go & ~s_burst);
			bus.counter_advance_n   <= ~(go & s_burst);
			bus.counter_clear_n     <= ~(go & s_clear);
			bus.upper_byte_strobe_n <= go ? s_be_n[1] : 1'b1;
			bus.lower_byte_strobe_n <= go ? s_be_n[0] : 1'b1;
			bus.pipelined           <= PIPELINED;
			bus.host_dq             <= s_wdata;
			bus.host_oe_n           <= ~(hit & s_write);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read return

	assign cap = PIPELINED ? rd_sh_r[2] : rd_sh_r[1]; // RL12

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_sh_r   <= 3'h0;
			rsp_valid <= 1'b0;
			rsp_data  <= '0;
		end else begin
			rd_sh_r   <= {rd_sh_r[1:0], hit & ~s_write};
			rsp_valid <= cap;
			if (cap) begin
				rsp_data <= bus.dq; // RL8
			end
		end
	end

	assign cmd_ready = ready_r;

endmodule
`default_nettype wire

//--- tb/dpr_port_asserts.sv
// Pin-level assertions on one flow-through RAM port
`timescale 1ns/1ps
`default_nettype none
module dpr_port_asserts
	import dpr_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_b,
	input wire logic [DPR_AW-1:0] addr,
	input wire logic              select_low_active,
	input wire logic              select_high_active,
	input wire logic              write_n,
	input wire logic              oe_n,
	input wire logic              address_strobe_n,
	input wire logic              counter_clear_n,
	input wire logic              upper_byte_strobe_n,
	input wire logic              lower_byte_strobe_n,
	input wire logic              pipelined,
	input wire logic [DPR_DW-1:0] dq,
	input wire logic [DPR_DW-1:0] dev_dq,
	input wire logic              dev_oe_n,
	input wire logic              host_oe_n
);
	////////////////////////////////////////////////////////////
	logic sel;
	logic rd;
	logic flow;
	assign sel  = !select_low_active && select_high_active;
	assign rd   = sel && write_n;
	assign flow = !pipelined;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////
	// Clear excluded: it would move the access to address zero
	sequence wr_rd_s;
		flow && sel && !write_n && !address_strobe_n && counter_clear_n
		&& !upper_byte_strobe_n && !lower_byte_strobe_n
		##1 rd && !oe_n && !address_strobe_n && counter_clear_n && $stable(addr);
	endsequence
	oe_async_a: assert property (oe_n |-> dev_oe_n)
		else $error("drives with output enable off");
	desel_float_a: assert property (flow && !sel |=> dev_oe_n)
		else $error("deselected port drives");
	desel_hold_a: assert property (flow && !sel ##1 !sel |=> dev_oe_n && $stable(dev_oe_n))
		else $error("idle port output not floating");
	read_drive_a: assert property (flow && rd && !oe_n |=> oe_n || !dev_oe_n)
		else $error("read not driven next cycle");
	write_quiet_a: assert property (flow && sel && !write_n |=> dev_oe_n)
		else $error("drives after a write");
	write_readback_a: assert property (wr_rd_s |=> dev_dq == $past(dq, 2))
		else $error("read after write returns wrong word");
	reset_quiet_a: assert property ($rose(rst_b) |-> dev_oe_n)
		else $error("drives straight after reset");
	no_fight_a: assert property (!(!dev_oe_n && !host_oe_n))
		else $error("both ends drive the data lines");
	cover property (flow && rd && !oe_n);
	cover property (sel && !write_n);
	cover property (wr_rd_s);
endmodule
`default_nettype wire

//--- tb/test_sync_dual_port_ram_port_logic.sv
// Testbench: two hosts on one RAM, left flow-through, right pipelined
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_sync_dual_port_ram_port_logic
	import dpr_pkg::*;
;
	localparam logic [DPR_DW-1:0] da = 18'h2a5a5;
	localparam logic [DPR_DW-1:0] db = 18'h15a3c;
	int                fails = 0;
	int                checks_done = 0;
	int                cyc = 0;
	logic              clk = 1'b0;
	logic              rst_b;
	logic              cv[2], cw[2], cb[2], cc[2], cr[2], rv[2];
	logic [DPR_AW:0]   ca[2];
	logic [DPR_DW-1:0] cd[2], rd[2];
	logic [1:0]        cbe[2];
	logic [DPR_DW-1:0] expq[2][$];
	int                tq[2][$];
	////////////////////////////////////////////////////////////
	dpr_if lif (.clk(clk));
	dpr_if rif (.clk(clk));
	dpr_ram u_dpr_ram (.clk(clk), .rst_b(rst_b), .lp(lif), .rp(rif));
	dpr_host #(.PIPELINED(1'b0)) u_dpr_host_l (.clk(clk), .rst_b(rst_b), .bus(lif),
		.cmd_valid(cv[0]), .cmd_ready(cr[0]), .cmd_write(cw[0]), .cmd_burst(cb[0]),
		.cmd_clear(cc[0]), .cmd_addr(ca[0]), .cmd_wdata(cd[0]), .cmd_be_n(cbe[0]),
		.rsp_valid(rv[0]), .rsp_data(rd[0]));
	dpr_host #(.PIPELINED(1'b1)) u_dpr_host_r (.clk(clk), .rst_b(rst_b), .bus(rif),
		.cmd_valid(cv[1]), .cmd_ready(cr[1]), .cmd_write(cw[1]), .cmd_burst(cb[1]),
		.cmd_clear(cc[1]), .cmd_addr(ca[1]), .cmd_wdata(cd[1]), .cmd_be_n(cbe[1]),
		.rsp_valid(rv[1]), .rsp_data(rd[1]));
	dpr_port_asserts u_dpr_port_asserts (.clk(clk), .rst_b(rst_b), .addr(lif.addr),
		.select_low_active(lif.select_low_active), .select_high_active(lif.select_high_active),
		.write_n(lif.write_n), .oe_n(lif.oe_n), .address_strobe_n(lif.address_strobe_n),
		.counter_clear_n(lif.counter_clear_n), .upper_byte_strobe_n(lif.upper_byte_strobe_n),
		.lower_byte_strobe_n(lif.lower_byte_strobe_n), .pipelined(lif.pipelined),
		.dq(lif.dq), .dev_dq(lif.dev_dq), .dev_oe_n(lif.dev_oe_n), .host_oe_n(lif.host_oe_n));
	always #(DPR_CLK_NS / 2) clk = ~clk;
	////////////////////////////////////////////////////////////
	// Valid stays up on return so commands can run back to back
	task automatic cmd(input int p, input logic w, input logic b, input logic c,
			input logic [DPR_AW:0] a, input logic [DPR_DW-1:0] d, input logic [1:0] be);
		int n;
		n = 0;
		cv[p] <= 1'b1;
		cw[p] <= w;
		cb[p] <= b;
		cc[p] <= c;
		ca[p] <= a;
		cd[p] <= d;
		cbe[p] <= be;
		do begin
			@(posedge clk);
			n++;
		end while (cr[p] !== 1'b1 && n < 20);
		`CHK("command taken", 1'b1, cr[p])
		if (!w && !a[DPR_AW]) begin
			expq[p].push_back(d);
			tq[p].push_back(cyc);
		end
	endtask
	task automatic idle_all(input int k);
		cv[0] <= 1'b0;
		cv[1] <= 1'b0;
		repeat (k) @(posedge clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// Off-bank reads push nothing, so any answer to them is flagged
	always @(posedge clk) begin
		logic [DPR_DW-1:0] ev;
		int                tk;
		cyc <= cyc + 1;
		for (int p = 0; p < 2; p++) begin
			if (rv[p] === 1'b1 && expq[p].size() == 0) begin
				`CHK("unexpected answer", 1'b0, 1'b1)
			end else if (rv[p] === 1'b1) begin
				ev = expq[p].pop_front();
				tk = tq[p].pop_front();
				`CHK("read data", ev, rd[p])
				`CHK("read latency", (p ? DPR_LAT_PIPE : DPR_LAT_FT) + 2, cyc - tk)
			end
		end
	end
	initial begin
		#(DPR_CLK_NS * 3000);
		fails++;
		report_and_stop();
	end
	initial begin
		rst_b = 1'b0;
		for (int p = 0; p < 2; p++) begin
			cv[p] = 1'b0;
			cw[p] = 1'b0;
			cb[p] = 1'b0;
			cc[p] = 1'b0;
			ca[p] = '0;
			cd[p] = '0;
			cbe[p] = 2'b11;
		end
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		cmd(0, 1, 0, 0, 15'h0100, da, 2'b00);
		cmd(0, 1, 0, 0, 15'h0101, db, 2'b00);
		cmd(0, 0, 0, 0, 15'h0101, db, 2'b11);
		cmd(0, 1, 0, 0, 15'h0100, 18'h00000, 2'b10);
		cmd(0, 1, 0, 0, 15'h0101, 18'h3ffff, 2'b01);
		cmd(0, 0, 0, 0, 15'h0100, {da[17:9], 9'h000}, 2'b11);
		cmd(0, 0, 0, 0, 15'h0101, {9'h1ff, db[8:0]}, 2'b11);
		for (int i = 0; i < 3; i++) begin
			cmd(0, 1, 0, 0, 15'(i), da ^ 18'(i), 2'b00);
		end
		cmd(0, 0, 1, 1, 15'h0155, da, 2'b11);
		cmd(0, 0, 1, 0, 15'h0155, da ^ 18'h1, 2'b11);
		cmd(0, 0, 1, 0, 15'h0155, da ^ 18'h2, 2'b11);
		cmd(0, 1, 0, 1, 15'h0077, db, 2'b00);
		cmd(0, 0, 0, 0, 15'h0000, db, 2'b11);
		cmd(0, 1, 0, 0, 15'h0201, db, 2'b00);
		cmd(0, 1, 0, 0, 15'h4201, 18'h00000, 2'b00);
		cmd(0, 0, 0, 0, 15'h4200, da, 2'b11);
		cmd(0, 0, 1, 0, 15'h0000, db, 2'b11);
		idle_all(4);
		cmd(1, 1, 0, 0, 15'h0300, da, 2'b00);
		cmd(1, 0, 0, 0, 15'h0300, da, 2'b11);
		idle_all(4);
		fork
			cmd(0, 0, 0, 0, 15'h0300, db, 2'b11);
			cmd(1, 1, 0, 0, 15'h0300, db, 2'b00);
		join
		idle_all(4);
		fork
			begin
				cmd(0, 1, 0, 0, 15'h0301, da, 2'b00);
				cmd(0, 1, 0, 0, 15'h0302, db, 2'b00);
				cv[0] <= 1'b0;
			end
			begin
				cmd(1, 0, 0, 0, 15'h0301, da, 2'b11);
				cmd(1, 0, 0, 0, 15'h0300, db, 2'b11);
				cmd(1, 0, 0, 0, 15'h0302, db, 2'b11);
			end
		join
		cmd(1, 0, 0, 0, 15'h0301, da, 2'b11);
		cmd(1, 1, 0, 0, 15'h0303, da, 2'b00);
		cmd(1, 0, 0, 0, 15'h0303, da, 2'b11);
		idle_all(8);
		`CHK("reads outstanding", 0, expq[0].size() + expq[1].size())
		report_and_stop();
	end
endmodule
`default_nettype wire
